/* dv/adcs_host.sv */
// host serial port model: select, link clock, command line, dout capture
`timescale 1ns/1ps
module adcs_host (
    // link pins toward the converter
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout_o,
    input  wire logic dout_oe
);
    logic [31:0] cap;
    logic        dout_w;

    // undriven dout floats, so the host sees no stale value
    assign dout_w = dout_oe ? dout_o : 1'bz;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b1;
        cap  = '0;
    end

    // two pulses while deselected let the link synchronisers clear
    task automatic idle_pulses();
        repeat (2) begin
            #16 sclk = 1'b1;
            #16 sclk = 1'b0;
        end
    endtask

    // select only moves while the link clock stands low
    task automatic select(input logic v);
        #17 cs_n = v;
    endtask

    // command msb first, then toggling filler; dout captured on each rise
    task automatic frame(input logic [7:0] cmd, input int n);
        for (int i = 0; i < n; i++) begin
            din = (i < 8) ? cmd[7-i] : ~din;
            #16 sclk = 1'b1;
            cap = {cap[30:0], dout_w};
            #16 sclk = 1'b0;
        end
    endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the converter serial command interface
`timescale 1ns/1ps
module testbench;
    import adcs_pkg::*;
    logic                clk, rstn, sclk, cs_n, din, dout_o, dout_oe;
    logic                eoc_n, fs_out, wws, shutdown, ref_on, buf_on;
    logic                ref_ready, fsi, track, osc_sample;
    logic [RESULT_W-1:0] res;
    logic [2:0]          link_chan, osc_chan;
    logic [11:0]         chans;
    int                  err_total, comparisons, trk, samples, fso_n;

    adcs_core #(.NCH(8), .REF_SETTLE(20), .CONV_CYC(16)) uut (
        .clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout_o(dout_o), .dout_oe(dout_oe), .eoc_n(eoc_n),
        .frame_sync_in(fsi), .frame_sync_out(fs_out),
        .word_width_select(wws), .conv_result(res),
        .link_chan(link_chan), .track(track), .osc_chan(osc_chan),
        .osc_sample(osc_sample),
        .shutdown(shutdown), .ref_on(ref_on), .buf_on(buf_on),
        .ref_ready(ref_ready));
    adcs_host host (.sclk(sclk), .cs_n(cs_n), .din(din),
        .dout_o(dout_o), .dout_oe(dout_oe));

    // 250 MHz system clock
    initial clk = 1'b0;
    always #2 clk = ~clk;

    // count track time, oscillator samples with channel, sync pulses
    always @(negedge clk) begin
        if (track === 1'b1) trk++;
        if (osc_sample === 1'b1) begin
            samples++;
            chans = {chans[8:0], osc_chan};
        end
    end
    always @(posedge fs_out) fso_n++;

    // compare one result against its expected value
    task automatic chk(input logic [31:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic clks(input int n);
        repeat (n) @(negedge clk);
    endtask

    // deselect, then confirm dout released and device asleep
    task automatic drop_select();
        host.select(1'b1);
        clks(4);
        chk(dout_oe, 1'b0, "dout enable");
        chk(shutdown, 1'b1, "shutdown");
        chk(eoc_n, 1'b1, "eoc released");
    endtask

    // plain frame in narrow mode, channel 5, external reference and clock
    task automatic t_narrow();
        host.select(1'b0);
        #8;
        chk(dout_oe, 1'b1, "dout enable");
        trk = 0;
        host.frame(8'hA6, 24);
        chk(trk, 28, "narrow track, 3.5 link periods");
        chk(link_chan, 3'h5, "channel");
        chk(host.cap[23:0], {8'h00, res, 2'b00}, "narrow word");
        chk(ref_on, 1'b0, "ref off in external mode");
        drop_select();
        $display("test narrow done");
    endtask

    // wide mode: dout stays low until fall 16
    task automatic t_wide();
        wws = 1'b1;
        res = 14'h1F03;
        host.select(1'b0);
        trk = 0;
        host.frame(8'h06, 32);
        chk(host.cap, {16'h0000, res, 2'b00}, "wide word");
        chk(trk, 92, "wide track, 11.5 link periods");
        drop_select();
        wws = 1'b0;
        $display("test wide done");
    endtask

    // power codes take effect on the select rise
    task automatic t_power();
        host.select(1'b0);
        host.frame(8'h00, 24);
        chk(ref_on, 1'b0, "old mode holds");
        drop_select();
        host.select(1'b0);
        clks(10);
        chk({ref_on, buf_on, ref_ready}, 3'h7, "all on");
        host.frame(8'h02, 24);
        drop_select();
        host.select(1'b0);
        clks(4);
        chk(ref_ready, 1'b0, "settling");
        clks(30);
        chk(ref_ready, 1'b1, "settled");
        drop_select();
        $display("test power done");
    endtask

    // select rise mid-conversion aborts; next frame is clean
    task automatic t_abort();
        host.select(1'b0);
        host.frame(8'h06, 12);
        drop_select();
        res = 14'h3FFF;
        host.select(1'b0);
        host.frame(8'h06, 24);
        chk(host.cap[23:0], {8'h00, res, 2'b00}, "after abort");
        drop_select();
        $display("test abort done");
    endtask

    // internal clock, scan 0..2, buffer-off mode, stored words read back
    task automatic t_internal();
        res = 14'h0C35;
        samples = 0;
        host.select(1'b0);
        host.frame(8'h4D, 8);
        clks(80);
        chk(eoc_n, 1'b0, "conversions done");
        chk(samples, 3, "scan length");
        chk(chans, 12'h00A, "scan order");
        host.frame(8'h00, 34);
        chk(host.cap, {res, 2'b00, res, 2'b00}, "stored words");
        drop_select();
        chk({ref_on, buf_on}, 2'h2, "buffer off mode");
        $display("test internal done");
    endtask

    // frame sync start: start edge carries a dummy bit, pulse marks msb
    task automatic t_dsp();
        chk(fso_n, 0, "no sync outside dsp");
        fsi = 1'b0;
        host.select(1'b0);
        host.frame(8'h03, 25);
        fsi = 1'b1;
        chk(host.cap[24:0], {9'h000, res, 2'b00}, "dsp word");
        chk(fso_n, 1, "frame sync pulses");
        drop_select();
        $display("test dsp done");
    endtask

    initial begin
        rstn = 1'b0;
        wws  = 1'b0;
        fsi  = 1'b1;
        chans = '0;
        res  = 14'h2A5C;
        err_total = 0;
        comparisons = 0;
        host.idle_pulses();
        clks(20);
        rstn = 1'b1;
        clks(4);
        chk({shutdown, dout_oe, eoc_n, ref_on}, 4'hA, "reset");
        t_narrow();
        t_wide();
        t_power();
        t_abort();
        t_internal();
        t_dsp();
        finish_test();
    end

    // watchdog against a hung link
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
endmodule

/* logic/adcs_core.sv */
// converter serial command interface: link, command word, internal scan
// Operation
// - select high shuts down, low resumes
// - select falling wakes and lets SCLK shift
// - DOUT low until 8th or 16th fall
// - result shifted out unsigned straight binary
// - frame-sync input starts an SCLK-paced conversion
// - frame-sync output marks result MSB on DOUT
// - external, internal, internal-with-scan modes
// - width input chooses 24 or 32 cycle frame
// - command fields: chan, scan, power, clock
// - power-up command: ch0, no scan, external
// - channel bits decode as binary input number
// - eight-channel scan codes, internal clock only
// - four-channel scan codes, internal clock only
// - power codes control reference and buffer
// - select high: DOUT off, chosen shutdown
// - external or running reference needs no settling; buffer-off mode still settles with the reference running
// - wide mode acquisition spans 11.5 cycles
// - DIN captured on rising SCLK from first
// - 24 cycles narrow; extra pulses give zeros
// - select high mid-conversion aborts to shutdown
// - new power mode applies on select rising
`timescale 1ns/1ps
module adcs_core #(
    parameter int NCH        = 8,
    parameter int REF_SETTLE = adcs_pkg::REF_SETTLE_CYC,
    parameter int CONV_CYC   = adcs_pkg::CONV_CYC
) (
    // system clock (internal oscillator) and reset
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // serial link pins
    input  wire logic                          sclk,
    input  wire logic                          cs_n,
    input  wire logic                          din,
    output logic                               dout_o,
    output logic                               dout_oe,
    output logic                               eoc_n,
    input  wire logic                          frame_sync_in,
    output logic                               frame_sync_out,
    input  wire logic                          word_width_select,
    // analog core, link side
    input  wire logic [adcs_pkg::RESULT_W-1:0] conv_result,
    output logic      [2:0]                    link_chan,
    output logic                               track,
    // analog core, oscillator side
    output logic      [2:0]                    osc_chan,
    output logic                               osc_sample,
    output logic                               shutdown,
    output logic                               ref_on,
    output logic                               buf_on,
    output logic                               ref_ready
);
    import adcs_pkg::*;

    localparam int          IW       = $clog2(NCH);
    localparam int          CW       = $clog2(CONV_CYC);
    localparam int          SW       = $clog2(REF_SETTLE + 1);
    localparam logic [2:0]  CHAN_MSK = 3'(NCH - 1);
    localparam logic [2:0]  MID      = 3'(NCH / 2);
    localparam logic [3:0]  NCH_W    = 4'(NCH);
    localparam logic [CW-1:0] CYC_LAST = CW'(CONV_CYC - 1);

    // ------------------------------------------------------------
    // link side, rising SCLK: command shift and edge count
    // ------------------------------------------------------------
    logic              link_rst_n;
    logic [5:0]        rise_cnt_r;
    logic [7:0]        cmd_sh_r;
    logic [2:0]        link_chan_r;
    logic              fs_d_r;
    logic              dsp_r;
    logic [7:0]        command_r;
    logic              cmd_tog_r;
    logic              wide_s;
    logic              done_s;
    logic              fs_start;
    logic              cmd_load;
    logic [5:0]        out_start;
    logic [5:0]        acq_end;
    logic [5:0]        fall_seen_r;

    // select high clears the frame logic at once
    assign link_rst_n = rstn & ~cs_n;
    assign fs_start   = fs_d_r & ~frame_sync_in;
    assign cmd_load   = rise_cnt_r == EDGE_CMD - 6'h01;
    assign out_start  = wide_s ? OUT_WIDE : OUT_NARROW;
    assign acq_end    = wide_s ? ACQ_END_WIDE : ACQ_END_NARROW;

    adcs_sync #(.W(1), .INIT(1'b0)) u_wide_sync (
        .clk  (sclk),
        .rstn (rstn),
        .d    (word_width_select),
        .q    (wide_s)
    );

    // frame counter, command shifter, channel pick on 3rd edge
    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rise_cnt_r  <= 6'h00;
            cmd_sh_r    <= 8'h00;
            link_chan_r <= 3'h0;
            fs_d_r      <= 1'b1;
            dsp_r       <= 1'b0;
        end else begin
            fs_d_r   <= frame_sync_in;
            cmd_sh_r <= {cmd_sh_r[6:0], din};
            if (fs_start) begin
                rise_cnt_r <= 6'h00;
                dsp_r      <= 1'b1;
            end else if (rise_cnt_r != EDGE_MAX) begin
                rise_cnt_r <= rise_cnt_r + 6'h01;
            end
            if (rise_cnt_r == EDGE_CHAN - 6'h01) begin
                link_chan_r <= {cmd_sh_r[1:0], din};
            end
        end
    end

    // command word survives select; only power-up resets it
    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            command_r <= CMD_RESET;
            cmd_tog_r <= 1'b0;
        end else if (cmd_load) begin
            command_r <= {cmd_sh_r[6:0], din};
            cmd_tog_r <= ~cmd_tog_r;
        end
    end

    assign link_chan = link_chan_r;
    // acquisition from 3rd rise to 6th or 14th fall
    assign track = (rise_cnt_r >= EDGE_CHAN) && (fall_seen_r < acq_end);

    // ------------------------------------------------------------
    // link side, falling SCLK: result shifter and frame sync out
    // ------------------------------------------------------------
    logic [WORD_W-1:0] out_sh_r;
    logic              fso_r;
    logic [3:0]        rd_idx_r;
    logic [4:0]        bits_left_r;
    logic [3:0]        res_cnt;
    logic              ext_load;
    logic              int_load;
    logic [RESULT_W-1:0] res_mem [0:NCH-1];

    // external clock: result leaves on the 8th or 16th fall
    assign ext_load = ~command_r[CLK_SRC_BIT] &&
                      rise_cnt_r == out_start;
    // internal clock: stored results leave once conversions end
    assign int_load = command_r[CLK_SRC_BIT] && done_s &&
                      rise_cnt_r >= EDGE_CMD &&
                      bits_left_r <= 5'h01 && rd_idx_r < res_cnt;

    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            out_sh_r    <= '0;
            fall_seen_r <= 6'h00;
            fso_r       <= 1'b0;
            rd_idx_r    <= 4'h0;
            bits_left_r <= 5'h00;
        end else begin
            fall_seen_r <= rise_cnt_r;
            fso_r       <= ext_load & dsp_r;
            if (ext_load) begin
                out_sh_r <= {conv_result, 2'b00};
            end else if (int_load) begin
                out_sh_r <= {res_mem[rd_idx_r[IW-1:0]], 2'b00};
            end else begin
                out_sh_r <= {out_sh_r[WORD_W-2:0], 1'b0};
            end
            if (int_load) begin
                rd_idx_r    <= rd_idx_r + 4'h1;
                bits_left_r <= WORD_BITS;
            end else if (bits_left_r != 5'h00) begin
                bits_left_r <= bits_left_r - 5'h01;
            end
        end
    end

    assign dout_o         = out_sh_r[WORD_W-1];
    assign dout_oe        = ~cs_n;
    assign frame_sync_out = fso_r;

    // ------------------------------------------------------------
    // system side: command copy, power control, reference settling
    // ------------------------------------------------------------
    logic              cs_s;
    logic              tog_s;
    logic              tog_d_r;
    logic              cs_d_r;
    logic              cmd_fresh_r;
    logic [7:0]        cmd_clk_r;
    logic [1:0]        pd_mode_r;
    logic [SW-1:0]     settle_r;
    logic              cmd_new;
    logic              cs_rise;
    logic              cs_fall;
    logic              needs_settle;

    adcs_sync #(.W(1), .INIT(1'b1)) u_cs_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (cs_n),
        .q    (cs_s)
    );

    adcs_sync #(.W(1), .INIT(1'b0)) u_tog_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (cmd_tog_r),
        .q    (tog_s)
    );

    assign cmd_new      = tog_s ^ tog_d_r;
    assign cs_rise      = cs_s & ~cs_d_r;
    assign cs_fall      = ~cs_s & cs_d_r;
    assign needs_settle = pd_mode_r == PD_ALL_OFF ||
                          pd_mode_r == PD_BUF_OFF;

    // command word copied on toggle; power mode taken on select rise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tog_d_r     <= 1'b0;
            cs_d_r      <= 1'b1;
            cmd_fresh_r <= 1'b0;
            cmd_clk_r   <= CMD_RESET;
            pd_mode_r   <= CMD_RESET[PD_HI:PD_LO];
        end else begin
            tog_d_r     <= tog_s;
            cs_d_r      <= cs_s;
            cmd_fresh_r <= cmd_new;
            if (cmd_new) begin
                cmd_clk_r <= command_r;
            end
            if (cs_rise) begin
                pd_mode_r <= cmd_clk_r[PD_HI:PD_LO];
            end
        end
    end

    // settling count only after a shutdown that stopped the reference buffer (all-off or buffer-off mode)
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            settle_r <= '0;
        end else if (cs_fall) begin
            settle_r <= needs_settle ? SW'(REF_SETTLE) : '0;
        end else if (settle_r != '0) begin
            settle_r <= settle_r - SW'(1);
        end
    end

    assign shutdown  = cs_s;
    assign ref_on    = (~cs_s & pd_mode_r != PD_EXTERNAL) |
                       pd_mode_r == PD_ALL_ON |
                       pd_mode_r == PD_BUF_OFF;
    assign buf_on    = (~cs_s & pd_mode_r != PD_EXTERNAL) |
                       pd_mode_r == PD_ALL_ON;
    assign ref_ready = ~cs_s & ~cs_d_r & settle_r == '0;

    // ------------------------------------------------------------
    // system side: internal clock conversions and channel scan
    // ------------------------------------------------------------
    adcs_state_t       state_r;
    logic [CW-1:0]     cyc_r;
    logic [3:0]        left_r;
    logic [2:0]        chan_r;
    logic [3:0]        idx_r;
    logic              rep_r;
    logic [2:0]        cmd_chan;
    logic [1:0]        scan_mode;
    logic              mid_ok;
    logic [2:0]        scan_first;
    logic [3:0]        scan_count;
    logic              scan_rep;
    logic              start;
    logic              mem_we;

    // scan list from the command: first channel, count, repeat
    assign cmd_chan   = cmd_clk_r[CHAN_HI:CHAN_LO] & CHAN_MSK;
    assign scan_mode  = cmd_clk_r[SCAN_HI:SCAN_LO];
    assign mid_ok     = scan_mode == SCAN_FROM_MID && cmd_chan >= MID;
    assign scan_rep   = scan_mode == SCAN_REPEAT;
    assign scan_first = scan_mode == SCAN_FROM_ZERO ? 3'h0 :
                        mid_ok ? MID : cmd_chan;
    assign scan_count = scan_mode == SCAN_FROM_ZERO ?
                            {1'b0, cmd_chan} + 4'h1 :
                        mid_ok ? {1'b0, cmd_chan} - {1'b0, MID} + 4'h1 :
                        scan_rep ? NCH_W : 4'h1;
    // only the oscillator mode converts here; link mode is SCLK paced
    assign start      = cmd_fresh_r & cmd_clk_r[CLK_SRC_BIT] & ~cs_s;
    assign mem_we     = state_r == ADCS_CONV && cyc_r == '0 && ~cs_s;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ADCS_IDLE;
            cyc_r   <= '0;
            left_r  <= 4'h0;
            chan_r  <= 3'h0;
            idx_r   <= 4'h0;
            rep_r   <= 1'b0;
        end else if (cs_s) begin
            state_r <= ADCS_IDLE;
        end else begin
            case (state_r)
                ADCS_IDLE: begin
                    if (start) begin
                        state_r <= ADCS_CONV;
                        cyc_r   <= CYC_LAST;
                        left_r  <= scan_count;
                        chan_r  <= scan_first;
                        idx_r   <= 4'h0;
                        rep_r   <= scan_rep;
                    end
                end
                ADCS_CONV: begin
                    if (cyc_r != '0) begin
                        cyc_r <= cyc_r - CW'(1);
                    end else begin
                        cyc_r  <= CYC_LAST;
                        idx_r  <= idx_r + 4'h1;
                        left_r <= left_r - 4'h1;
                        if (!rep_r) begin
                            chan_r <= chan_r + 3'h1;
                        end
                        if (left_r == 4'h1) begin
                            state_r <= ADCS_DONE;
                        end
                    end
                end
                ADCS_DONE: begin
                    state_r <= ADCS_DONE;
                end
                default: begin
                    state_r <= ADCS_IDLE;
                end
            endcase
        end
    end

    // result store, read by the link once done is seen there
    always_ff @(posedge clk) begin
        if (mem_we) begin
            res_mem[idx_r[IW-1:0]] <= conv_result;
        end
    end

    adcs_sync #(.W(1), .INIT(1'b0)) u_done_sync (
        .clk  (sclk),
        .rstn (rstn),
        .d    (state_r == ADCS_DONE),
        .q    (done_s)
    );

    assign res_cnt    = idx_r;
    assign osc_chan   = chan_r;
    assign osc_sample = state_r == ADCS_CONV && cyc_r == CYC_LAST;
    assign eoc_n      = state_r != ADCS_DONE;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_dout_quiet;
        @(posedge sclk) disable iff (!link_rst_n)
        (rise_cnt_r < 6'h07 && !done_s && !wide_s) |-> !dout_o;
    endproperty
    a_dout_quiet: assert property (p_dout_quiet)
        else $error("dout left low level before result start");

    property p_msb_out;
        @(negedge sclk) disable iff (!link_rst_n)
        ext_load |=> dout_o == $past(conv_result[RESULT_W-1]);
    endproperty
    a_msb_out: assert property (p_msb_out)
        else $error("result msb not on dout at start fall");

    property p_cmd_load;
        @(posedge sclk) disable iff (!link_rst_n)
        cmd_load |=> command_r == {$past(cmd_sh_r[6:0]), $past(din)};
    endproperty
    a_cmd_load: assert property (p_cmd_load)
        else $error("command word not loaded on 8th rise");

    property p_chan_pick;
        @(posedge sclk) disable iff (!link_rst_n)
        rise_cnt_r == 6'h02 |=> link_chan == {$past(cmd_sh_r[1:0]), $past(din)};
    endproperty
    a_chan_pick: assert property (p_chan_pick)
        else $error("channel not picked on 3rd rise");

    property p_fso;
        @(negedge sclk) disable iff (!link_rst_n)
        (ext_load && dsp_r) |=> frame_sync_out ##1 !frame_sync_out;
    endproperty
    a_fso: assert property (p_fso)
        else $error("frame sync out not a one-cycle pulse at msb");

    property p_pd_latch;
        @(posedge clk) disable iff (!rstn)
        cs_rise |=> pd_mode_r == $past(cmd_clk_r[PD_HI:PD_LO]);
    endproperty
    a_pd_latch: assert property (p_pd_latch)
        else $error("power mode not taken on select rise");

    property p_abort;
        @(posedge clk) disable iff (!rstn)
        (cs_s && state_r != ADCS_IDLE) |=> state_r == ADCS_IDLE && eoc_n;
    endproperty
    a_abort: assert property (p_abort)
        else $error("conversion not aborted by select high");

    property p_ready_fast;
        @(posedge clk) disable iff (!rstn)
        (cs_fall && !needs_settle) |=> cs_s || ref_ready;
    endproperty
    a_ready_fast: assert property (p_ready_fast)
        else $error("reference not ready at once when running");

    property p_ext_off;
        @(posedge clk) disable iff (!rstn)
        pd_mode_r == PD_EXTERNAL |-> !ref_on && !buf_on;
    endproperty
    a_ext_off: assert property (p_ext_off)
        else $error("internal reference on in external mode");

    property p_repeat;
        @(posedge clk) disable iff (!rstn)
        (state_r == ADCS_IDLE && start && scan_rep) |=>
            left_r == NCH_W && chan_r == $past(cmd_chan);
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("repeat scan not set to channel count");

    property p_track_end;
        @(negedge sclk) disable iff (!link_rst_n)
        (rise_cnt_r == ACQ_END_WIDE && wide_s) |=> !track;
    endproperty
    a_track_end: assert property (p_track_end)
        else $error("wide acquisition not ended on 14th fall");

endmodule

/* logic/adcs_pkg.sv */
// package: constants and types of the converter serial command interface
package adcs_pkg;

    // ------------------------------------------------------------
    // command word layout and value after power-up
    // ------------------------------------------------------------
    localparam int          CMD_W       = 8;
    localparam int          CHAN_HI     = 7;
    localparam int          CHAN_LO     = 5;
    localparam int          SCAN_HI     = 4;
    localparam int          SCAN_LO     = 3;
    localparam int          PD_HI       = 2;
    localparam int          PD_LO       = 1;
    localparam int          CLK_SRC_BIT = 0;
    localparam logic [7:0]  CMD_RESET   = 8'h06;

    // ------------------------------------------------------------
    // reference/power-down and scan codes
    // ------------------------------------------------------------
    localparam logic [1:0]  PD_ALL_ON      = 2'h0;
    localparam logic [1:0]  PD_ALL_OFF     = 2'h1;
    localparam logic [1:0]  PD_BUF_OFF     = 2'h2;
    localparam logic [1:0]  PD_EXTERNAL    = 2'h3;
    localparam logic [1:0]  SCAN_SINGLE    = 2'h0;
    localparam logic [1:0]  SCAN_FROM_ZERO = 2'h1;
    localparam logic [1:0]  SCAN_FROM_MID  = 2'h2;
    localparam logic [1:0]  SCAN_REPEAT    = 2'h3;

    // ------------------------------------------------------------
    // link edge counts and word sizes
    // ------------------------------------------------------------
    localparam logic [5:0]  EDGE_CHAN      = 6'h03;
    localparam logic [5:0]  EDGE_CMD       = 6'h08;
    localparam logic [5:0]  ACQ_END_NARROW = 6'h06;
    localparam logic [5:0]  ACQ_END_WIDE   = 6'h0E;
    localparam logic [5:0]  OUT_NARROW     = 6'h08;
    localparam logic [5:0]  OUT_WIDE       = 6'h10;
    localparam logic [5:0]  EDGE_MAX       = 6'h3F;
    localparam logic [4:0]  WORD_BITS      = 5'h10;
    localparam int          RESULT_W       = 14;
    localparam int          WORD_W         = 16;

    // ------------------------------------------------------------
    // timing on the 250 MHz system clock
    // ------------------------------------------------------------
    localparam int          CLK_MHZ        = 250;
    localparam int          REF_SETTLE_MS  = 5;
    localparam int          REF_SETTLE_CYC = REF_SETTLE_MS * 1000 * CLK_MHZ;
    localparam int          CONV_CYC       = 16;

    typedef enum logic [1:0] {ADCS_IDLE, ADCS_CONV, ADCS_DONE} adcs_state_t;

endpackage

/* logic/adcs_sync.sv */
// two-flop level synchroniser
`timescale 1ns/1ps
module adcs_sync #(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    // first flop feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= INIT;
            q      <= INIT;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule
